// ### rtl/ioe_pkg.sv
// Constants and carrier types for the I/O drive and change-flag block.
// Assumes an eight-line port and a command-byte register addressing scheme.
package ioe_pkg;
  localparam int          IOE_LINES     = 8;           // Port width
  localparam logic [7:0]  IOE_ADDR_DRV  = 8'h02;       // Output drive configuration
  localparam logic [7:0]  IOE_ADDR_FLAG = 8'h03;       // Change flags, clear on read
  localparam logic [7:0]  IOE_DRV_RST   = 8'h00;       // All outputs open-drain
  localparam logic [7:0]  IOE_FLAG_RST  = 8'h00;       // No events pending
  localparam logic [7:0]  IOE_FAN_MASK  = 8'hF0;       // Lines taken over by fan mode
  localparam int          IOE_FAN_LSB   = 4;           // First fan-controlled line

  // Register access request from the serial-bus transaction logic
  typedef struct packed {
    logic [7:0] cmd;     // Command byte (register address)
    logic       wr;      // Write strobe, one cycle
    logic       rd;      // Read strobe, one cycle
    logic [7:0] wdata;   // Write data
  } ioe_req_t;

  // Pad drive for the eight lines
  typedef struct packed {
    logic [7:0] level;   // Level driven when enabled
    logic [7:0] enable;  // High while the pad is driven
  } ioe_pad_t;
endpackage

// ### rtl/ioe_port.sv
// Output drive selection, fan-mode takeover and input-change flags.
// Assumes direction, data, fan mode and fan pattern come from registers on the same clock.
`timescale 1ns/1ns
`default_nettype none
module ioe_port (
  input  wire logic             sys_clk_in,     // 20 MHz clock
  input  wire logic             reset_in,       // Synchronous, active high
  input  wire ioe_pkg::ioe_req_t req_in,        // Register access
  input  wire logic [7:0]       direction_in,   // One per line: 1 = output
  input  wire logic [7:0]       data_in,        // Output values per line
  input  wire logic             fan_mode_in,    // Fan mode enable from device_config
  input  wire logic [3:0]       fan_pattern_in, // {fan_shutdown_n, fan_speed_select_n[2:0]}
  input  wire logic [7:0]       io_line_in,     // Pad levels, asynchronous
  output ioe_pkg::ioe_pad_t     io_line_out,    // Pad level and enable
  output logic [7:0]            rd_data_out,    // Read data
  output logic                  rd_valid_out,   // Read answered by this block
  output logic [7:0]            change_flag_out,// Change flags
  output logic [7:0]            drive_type_out  // Drive configuration
);
  import ioe_pkg::*;

  logic [7:0] line_sync;     // Synchronised pad levels
  logic [7:0] line_prev;     // Previous synchronised levels
  logic [7:0] fan_lines;     // Lines under fan control
  logic [7:0] out_mask;      // Effective output lines
  logic [7:0] in_mask;       // Effective input lines
  logic [7:0] change;        // Qualified change events
  logic [7:0] drive_val;     // Value to drive per line
  logic       flag_read;     // Read of the flag register
  logic       drv_read;      // Read of the drive register
  ioe_pad_t   next_pad;      // Next pad drive
  logic [2:0] sample_ok;     // Valid bit per stage: stage1, sync, prev

  // Decode a command against one address with a strobe
  function automatic logic hit(input logic [7:0] cmd, input logic [7:0] addr, input logic strobe);
    hit = strobe && (cmd == addr);
  endfunction

  ioe_sync u_sync (
    .sys_clk_in (sys_clk_in),
    .reset_in   (reset_in),
    .async_in   (io_line_in),
    .sync_out   (line_sync)
  );

  // Line roles and events
  always_comb begin
    fan_lines = fan_mode_in ? IOE_FAN_MASK : 8'h00;
    out_mask  = direction_in | fan_lines;
    in_mask   = ~out_mask;
    // Edges count only once the sample pipeline has filled
    change    = (line_sync ^ line_prev) & in_mask & {8{sample_ok[2]}};
    drive_val = data_in;
    if (fan_mode_in) begin
      drive_val[7:IOE_FAN_LSB] = fan_pattern_in;
    end
    flag_read = hit(req_in.cmd, IOE_ADDR_FLAG, req_in.rd);
    drv_read  = hit(req_in.cmd, IOE_ADDR_DRV, req_in.rd);
  end

  // Pad drive per line
  genvar gi;
  generate
    for (gi = 0; gi < IOE_LINES; gi++) begin : g_drive
      always_comb begin
        if (!out_mask[gi]) begin
          // Input: pad released
          next_pad.level[gi]  = 1'b0;
          next_pad.enable[gi] = 1'b0;
        end else if (drive_type_out[gi] && !fan_lines[gi]) begin
          // Push-pull drives both levels
          next_pad.level[gi]  = drive_val[gi];
          next_pad.enable[gi] = 1'b1;
        end else begin
          // Open-drain pulls low only
          next_pad.level[gi]  = 1'b0;
          next_pad.enable[gi] = ~drive_val[gi];
        end
      end
    end
  endgenerate

  // Registered pad outputs
  // Registered so pad enables never glitch between edges
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      io_line_out <= '0;
    end else begin
      io_line_out <= next_pad;
    end
  end

  // Previous level tracker
  // Runs always, so a direction change alone never flags
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      line_prev <= 8'h00;
    end else begin
      line_prev <= line_sync;
    end
  end

  // Pipeline fill tracker; the synchroniser's reset zeros are not pad
  // levels, so no edge counts until line_prev holds a real sample
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      sample_ok <= 3'h0;
    end else begin
      sample_ok <= {sample_ok[1:0], 1'h1};
    end
  end

  // Drive configuration register, writable
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      drive_type_out <= IOE_DRV_RST;
    end else if (hit(req_in.cmd, IOE_ADDR_DRV, req_in.wr)) begin
      drive_type_out <= req_in.wdata;
    end
  end

  // Change flags; writes ignored, set only from input lines through in_mask
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      change_flag_out <= IOE_FLAG_RST;
    end else if (flag_read) begin
      // Clear all, but keep this cycle's events
      change_flag_out <= change;
    end else begin
      change_flag_out <= change_flag_out | change;
    end
  end

  // Read data capture
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      rd_data_out  <= 8'h00;
      rd_valid_out <= 1'b0;
    end else begin
      rd_valid_out <= flag_read || drv_read;
      if (flag_read) begin
        rd_data_out <= change_flag_out;
      end else if (drv_read) begin
        rd_data_out <= drive_type_out;
      end else if (req_in.rd) begin
        // Unmapped read: zero, no valid strobe
        rd_data_out <= 8'h00;
      end
    end
  end

  // Checks
  a_flags_reset: assert property (@(posedge sys_clk_in) reset_in |=> change_flag_out == 8'h00)
    else $error("flags not zero after reset");
  a_push_pull: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    ##1 ($past(direction_in[0]) && $past(drive_type_out[0]) && !$past(reset_in))
    |-> (io_line_out.enable[0] && io_line_out.level[0] == $past(data_in[0])))
    else $error("push-pull drive wrong");
  a_open_drain: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    ##1 ($past(direction_in[1]) && !$past(drive_type_out[1]) && !$past(reset_in))
    |-> (!io_line_out.level[1] && io_line_out.enable[1] == !$past(data_in[1])))
    else $error("open-drain drive wrong");
  a_fan_drive: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    fan_mode_in |=> (io_line_out.enable[7:4] == ~$past(fan_pattern_in)))
    else $error("fan lines not driven as outputs");
  a_fan_od_only: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    (fan_mode_in && drive_type_out[7:4] == 4'hF) |=> (io_line_out.level[7:4] == 4'h0))
    else $error("fan lines driven push-pull");
  a_input_only: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    ##1 !$past(reset_in) |-> ((change_flag_out & ~($past(in_mask) | $past(change_flag_out))) == 8'h00))
    else $error("flag set on output line");
  a_fan_no_flag: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    fan_mode_in |=> ((change_flag_out[7:4] & ~$past(change_flag_out[7:4])) == 4'h0))
    else $error("fan line set a flag");
  a_change_sets: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    (change != 8'h00) |=> ((change_flag_out & $past(change)) == $past(change)))
    else $error("change not flagged");
  a_read_clears: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    flag_read |=> (rd_data_out == $past(change_flag_out) && rd_valid_out && change_flag_out == $past(change)))
    else $error("flag read did not capture and clear");
  a_read_keeps: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    (flag_read && change != 8'h00) |=> (change_flag_out != 8'h00))
    else $error("event lost during clearing read");
  // Drive checks
  a_input_undriven: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    1'h1 |=> ((io_line_out.enable & ~($past(direction_in) | ($past(fan_mode_in) ? IOE_FAN_MASK : 8'h00))) == 8'h00))
    else $error("input line driven");
  a_fan_level_low: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    fan_mode_in |=> (io_line_out.level[7:4] == 4'h0))
    else $error("fan line driven high");
  a_drive_write: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    hit(req_in.cmd, IOE_ADDR_DRV, req_in.wr) |=> (drive_type_out == $past(req_in.wdata)))
    else $error("drive write did not land");
  a_drive_readback: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    drv_read |=> (rd_valid_out && rd_data_out == $past(drive_type_out)))
    else $error("drive readback wrong");
  // Flag checks
  a_flag_sticky: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    !flag_read |=> ((change_flag_out & $past(change_flag_out)) == $past(change_flag_out)))
    else $error("flag lost without read");
  a_flag_exact: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    1'h1 |=> ((change_flag_out & ~$past(change_flag_out) & ~$past(change)) == 8'h00))
    else $error("flag set without change");
  a_flag_nowrite: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    (hit(req_in.cmd, IOE_ADDR_FLAG, req_in.wr) && !flag_read) |=> (change_flag_out == ($past(change_flag_out) | $past(change))))
    else $error("flag register took a write");
endmodule
`default_nettype wire

// ### rtl/ioe_sync.sv
// Two-stage synchroniser for the eight pad inputs.
// Assumes pad levels are asynchronous to sys_clk_in.
`timescale 1ns/1ns
`default_nettype none
module ioe_sync (
  input  wire logic       sys_clk_in,
  input  wire logic       reset_in,
  input  wire logic [7:0] async_in,
  output logic      [7:0] sync_out
);
  import ioe_pkg::*;

  logic [7:0] stage1;  // First stage, read only by second stage

  // Two flip-flops per line
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      stage1   <= 8'h00;
      sync_out <= 8'h00;
    end else begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end
endmodule
`default_nettype wire

// ### tb/io_drive_config_and_change_flags_bench.sv
// Self-checking bench for the drive selection and change-flag block.
// Assumes pads have pull-ups; undriven lines follow the external level ext.
`timescale 1ns/1ns
`default_nettype none
module io_drive_config_and_change_flags_bench;
  import ioe_pkg::*;
  logic sys_clk_in, reset_in, fan_mode_in, rd_valid_out, v;
  logic [7:0] direction_in, data_in, ext, io_line_in, rd_data_out, change_flag_out, drive_type_out, d;
  logic [3:0] fan_pattern_in;
  ioe_req_t req_in;
  ioe_pad_t io_line_out;
  int fail_count, cmp_count;
  // Wire level: driven level when enabled, else the outside world
  assign io_line_in = (io_line_out.enable & io_line_out.level) | (~io_line_out.enable & ext);
  ioe_port dut (.sys_clk_in, .reset_in, .req_in, .direction_in, .data_in, .fan_mode_in, .fan_pattern_in,
    .io_line_in, .io_line_out, .rd_data_out, .rd_valid_out, .change_flag_out, .drive_type_out);
  ioe_host_model host (.sys_clk_in, .rd_data_in(rd_data_out), .rd_valid_in(rd_valid_out), .req_out(req_in));
  always #25 sys_clk_in = ~sys_clk_in; // 20 MHz
  // Compare and count
  task chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task stop_test;
    if (fail_count == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Let pads settle, then clear flags by a read
  task settle_clear;
    repeat (4) @(posedge sys_clk_in);
    host.read_reg(IOE_ADDR_FLAG, d, v);
  endtask
  // Push-pull low nibble, open-drain high nibble, readback, flag write ignored
  task t_drive;
    host.write_reg(IOE_ADDR_DRV, 8'h0F);
    direction_in <= 8'hFF;
    data_in <= 8'hAA;
    repeat (3) @(posedge sys_clk_in);
    chk(io_line_out.enable, 8'h5F);
    chk(io_line_out.level, 8'h0A);
    host.read_reg(IOE_ADDR_DRV, d, v);
    chk(d, 8'h0F);
    chk({7'h00, v}, 8'h01);
    host.write_reg(IOE_ADDR_FLAG, 8'hFF);
    repeat (4) @(posedge sys_clk_in);
    chk(change_flag_out, 8'h00);
    host.write_reg(IOE_ADDR_DRV, 8'h00);
    repeat (2) @(posedge sys_clk_in);
    chk(io_line_out.enable, 8'h55);
    chk(io_line_out.level, 8'h00);
  endtask
  // Fan mode takes the upper lines, open-drain, no flags from them
  task t_fan;
    host.write_reg(IOE_ADDR_DRV, 8'hFF);
    fan_mode_in <= 1'h1;
    fan_pattern_in <= 4'h5;
    direction_in <= 8'h00;
    settle_clear();
    chk(io_line_out.enable, 8'hA0);
    chk(io_line_out.level, 8'h00);
    ext <= 8'h00;
    repeat (5) @(posedge sys_clk_in);
    chk(change_flag_out, 8'h0F);
    host.read_reg(8'h7F, d, v);
    chk(d, 8'h00);
    chk({7'h00, v}, 8'h00);
    chk(change_flag_out, 8'h0F);
  endtask
  // Change landing on the clearing read survives; next read clears all
  task t_clear;
    @(posedge sys_clk_in);
    fan_mode_in <= 1'h0;
    settle_clear();
    ext <= 8'h01;
    @(posedge sys_clk_in);
    host.read_reg(IOE_ADDR_FLAG, d, v);
    chk(d, 8'h00);
    chk(change_flag_out, 8'h01);
    host.read_reg(IOE_ADDR_FLAG, d, v);
    chk(d, 8'h01);
    chk(change_flag_out, 8'h00);
  endtask
  initial begin
    repeat (5000) @(posedge sys_clk_in);
    fail_count++;
    stop_test();
  end
  initial begin
    sys_clk_in = 1'h0;
    reset_in = 1'h1;
    direction_in = 8'h00;
    data_in = 8'h00;
    fan_mode_in = 1'h0;
    fan_pattern_in = 4'h0;
    ext = 8'hFF;
    repeat (16) @(posedge sys_clk_in);
    reset_in <= 1'h0;
    repeat (4) @(posedge sys_clk_in);
    chk(change_flag_out, IOE_FLAG_RST);
    chk(drive_type_out, IOE_DRV_RST);
    t_drive();
    t_fan();
    t_clear();
    stop_test();
  end
endmodule
`default_nettype wire

// ### tb/ioe_host_model.sv
// Host-side model issuing register requests to the port block.
// Assumes it shares the block clock; strobes change just after a rising edge.
`timescale 1ns/1ns
`default_nettype none
module ioe_host_model (
  input  wire logic          sys_clk_in,  // Shared clock
  input  wire logic [7:0]    rd_data_in,  // Read data from block
  input  wire logic          rd_valid_in, // Read answer strobe
  output ioe_pkg::ioe_req_t  req_out      // Request to block
);
  import ioe_pkg::*;
  initial req_out = '0; // Idle bus at time zero
  // One-cycle write strobe, then idle
  task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
    @(posedge sys_clk_in);
    req_out <= '{cmd: addr, wr: 1'h1, rd: 1'h0, wdata: data};
    @(posedge sys_clk_in);
    req_out.wr <= 1'h0;
  endtask
  // One-cycle read strobe; answer sampled in the cycle after it is taken
  task automatic read_reg(input logic [7:0] addr, output logic [7:0] data, output logic valid);
    @(posedge sys_clk_in);
    req_out <= '{cmd: addr, wr: 1'h0, rd: 1'h1, wdata: 8'h00};
    @(posedge sys_clk_in);
    req_out.rd <= 1'h0;
    #1;
    data = rd_data_in;
    valid = rd_valid_in;
  endtask
endmodule
`default_nettype wire
